// ### pkg/thc_consts.svh
// Purpose: constants for the two-hand control monitor
// Notes: times in ms, counts derived from the 25 MHz clock
`ifndef THC_CONSTS_SVH
`define THC_CONSTS_SVH
`define THC_CLK_HZ 25000000
`define THC_SYNC_MS 500
`define THC_DISC_MAX_MS 500
`define THC_DISC_STEP_MS 10
`define THC_DISC_DEF_MS 30
`define THC_DISC_DEF_STEPS 6'h03
`define THC_DISC_MAX_STEPS 6'h32
`define THC_MS_CYCLES ((`THC_CLK_HZ / 1000))
`define THC_STEP_CYCLES (`THC_DISC_STEP_MS * `THC_MS_CYCLES)
`define THC_SYNC_CYCLES (`THC_SYNC_MS * `THC_MS_CYCLES)
`endif

// ### pkg/thc_pkg.sv
// Purpose: types for the two-hand control monitor
// Assumes: nothing
// Notes: gray-coded states along the usual path
package thc_pkg;
	typedef enum logic [1:0] {
		THC_ARMED = 2'b00,
		THC_WAIT = 2'b01,
		THC_ON = 2'b11,
		THC_LOCK = 2'b10
	} thc_state_t;
endpackage : thc_pkg

// ### logic/thc_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: asynchronous input
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
module thc_sync3 (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic d_in,
	output logic q_out
);
	logic s1_r, s2_r, s3_r;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q_out <= 1'b0;
		end else if (s2_r == s3_r) begin
			q_out <= s3_r;
		end
	end
endmodule : thc_sync3

// ### logic/thc_disc_timer.sv
// Purpose: per-pair discrepancy timer
// Assumes: setting in 10 ms steps, 0 disables
// Notes: clear restarts the timer and drops the error, except when the error is set in the same cycle
`timescale 1ns/10ps
`include "thc_consts.svh"
module thc_disc_timer #(
	parameter int STEP_CYCLES = `THC_STEP_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clear_in,
	input wire logic disagree_in,
	input wire logic [5:0] steps_in,
	output logic err_out
);
	logic [19:0] pre_r;
	logic [5:0] steps_r;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_r <= 20'h00000;
			steps_r <= 6'h00;
		end else if (clear_in || !disagree_in || steps_in == 6'h00) begin
			pre_r <= 20'h00000;
			steps_r <= 6'h00;
		end else if (pre_r == 20'(STEP_CYCLES - 1)) begin
			pre_r <= 20'h00000;
			if (steps_r != 6'h3f) begin
				steps_r <= steps_r + 6'h01;
			end
		end else begin
			pre_r <= pre_r + 20'h00001;
		end
	end
	// error latches; only clear drops it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_out <= 1'b0;
		end else if (steps_in != 6'h00 && disagree_in && steps_r >= steps_in) begin
			err_out <= 1'b1;
		end else if (clear_in) begin
			err_out <= 1'b0;
		end
	end
endmodule : thc_disc_timer

// ### logic/thc_monitor.sv
// Purpose: two-hand control monitor, two NO/NC contact pairs
// Assumes: run_in high means run mode; rising edge is idle-to-run
// Notes: discrepancy setting in 10 ms steps, values above 50 clamp
//        window overrun only locks the enable and raises no flag
//        settings take effect one clock after they change
`timescale 1ns/10ps
`include "thc_consts.svh"
module thc_monitor #(
	parameter int STEP_CYCLES = `THC_STEP_CYCLES,
	parameter int SYNC_CYCLES = `THC_SYNC_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic p1_no_in,
	input wire logic p1_nc_in,
	input wire logic p2_no_in,
	input wire logic p2_nc_in,
	input wire logic [5:0] disc1_steps_in,
	input wire logic [5:0] disc2_steps_in,
	input wire logic use_disc1_in,
	input wire logic use_disc2_in,
	input wire logic use_fault_in,
	output logic out_enable_out,
	output logic disc_err1_out,
	output logic disc_err2_out,
	output logic fault_present_out
);
	// ==========================================================
	// input conditioning
	// contacts bounce; the agreement stage costs a cycle but keeps a
	// single odd sample from reaching the timers
	logic no1;
	logic nc1;
	logic no2;
	logic nc2;
	logic run_s;

	thc_sync3 u_s0 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(p1_no_in),
		.q_out(no1)
	);

	thc_sync3 u_s1 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(p1_nc_in),
		.q_out(nc1)
	);

	thc_sync3 u_s2 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(p2_no_in),
		.q_out(no2)
	);

	thc_sync3 u_s3 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(p2_nc_in),
		.q_out(nc2)
	);

	thc_sync3 u_s4 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(run_in),
		.q_out(run_s)
	);

	// a run level already high when reset ends still counts as a
	// start, so power-up behaves like an idle-to-run change
	logic run_r;
	logic start;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_r <= 1'b0;
		end else begin
			run_r <= run_s;
		end
	end
	assign start = run_s && !run_r;

	// ==========================================================
	// pair evaluation
	// active: closer on, opener off; idle is the exact opposite
	logic act1;
	logic act2;
	logic idle1;
	logic idle2;
	logic dis1;
	logic dis2;

	assign act1 = no1 && !nc1;
	assign act2 = no2 && !nc2;
	assign idle1 = !no1 && nc1;
	assign idle2 = !no2 && nc2;
	// disagreement covers both a stuck closer and a broken opener
	assign dis1 = no1 == nc1;
	assign dis2 = no2 == nc2;

	// settings pass a register so that a change lands on both
	// comparators of a timer in the same cycle; out-of-range
	// values clamp to the longest time
	logic [5:0] st1_r;
	logic [5:0] st2_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st1_r <= `THC_DISC_DEF_STEPS;
		end else if (disc1_steps_in > `THC_DISC_MAX_STEPS) begin
			st1_r <= `THC_DISC_MAX_STEPS;
		end else begin
			st1_r <= disc1_steps_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st2_r <= `THC_DISC_DEF_STEPS;
		end else if (disc2_steps_in > `THC_DISC_MAX_STEPS) begin
			st2_r <= `THC_DISC_MAX_STEPS;
		end else begin
			st2_r <= disc2_steps_in;
		end
	end

	// ==========================================================
	// discrepancy timers and error recovery
	logic err1;
	logic err2;
	logic any_err;
	logic both_idle_seen_r;
	logic err_clear;

	// clear after both inactive then both active, or at start
	// both timers share one clear: apart from start, recovery needs both hands
	assign err_clear = start || (both_idle_seen_r && act1 && act2);
	thc_disc_timer #(.STEP_CYCLES(STEP_CYCLES)) u_t1 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(err_clear),
		.disagree_in(dis1 && run_s),
		.steps_in(st1_r),
		.err_out(err1)
	);
	thc_disc_timer #(.STEP_CYCLES(STEP_CYCLES)) u_t2 (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(err_clear),
		.disagree_in(dis2 && run_s),
		.steps_in(st2_r),
		.err_out(err2)
	);
	assign any_err = err1 || err2;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			both_idle_seen_r <= 1'b0;
		end else if (start) begin
			both_idle_seen_r <= 1'b0;
		end else if (!any_err) begin
			// nothing to recover from; forget any earlier release
			both_idle_seen_r <= 1'b0;
		end else if (idle1 && idle2) begin
			both_idle_seen_r <= 1'b1;
		end else if (err_clear) begin
			both_idle_seen_r <= 1'b0;
		end
	end

	// ==========================================================
	// enable state machine with synchronisation window
	thc_pkg::thc_state_t state_r;
	thc_pkg::thc_state_t state_nxt;
	logic [24:0] sync_cnt_r;
	logic sync_over;
	// window count runs only while one hand waits for the other and
	// stops at the limit, so a long wait cannot wrap back into it
	assign sync_over = sync_cnt_r >= 25'(SYNC_CYCLES);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			thc_pkg::THC_ARMED: begin
				if (any_err) begin
					state_nxt = thc_pkg::THC_LOCK;
				end else if (act1 && act2) begin
					state_nxt = thc_pkg::THC_ON;
				end else if (act1 || act2) begin
					// first hand down opens the window
					state_nxt = thc_pkg::THC_WAIT;
				end
			end
			thc_pkg::THC_WAIT: begin
				if (any_err) begin
					state_nxt = thc_pkg::THC_LOCK;
				end else if (act1 && act2 && !sync_over) begin
					state_nxt = thc_pkg::THC_ON;
				end else if (!act1 && !act2) begin
					state_nxt = thc_pkg::THC_ARMED;
				end else if (sync_over) begin
					state_nxt = thc_pkg::THC_LOCK;
				end
			end
			thc_pkg::THC_ON: begin
				// either hand leaving ends the cycle for good
				if (any_err) begin
					state_nxt = thc_pkg::THC_LOCK;
				end else if (!act1 || !act2) begin
					state_nxt = thc_pkg::THC_LOCK;
				end
			end
			default: begin
				// both hands must leave before a new attempt
				if (!any_err && !act1 && !act2) begin
					state_nxt = thc_pkg::THC_ARMED;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= thc_pkg::THC_LOCK;
		end else if (start) begin
			state_r <= thc_pkg::THC_LOCK;
		end else if (!run_s) begin
			// idle mode is a safe state; nothing may enable
			state_r <= thc_pkg::THC_LOCK;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_cnt_r <= 25'h0000000;
		end else if (start) begin
			sync_cnt_r <= 25'h0000000;
		end else if (state_r != thc_pkg::THC_WAIT) begin
			// the window restarts with every fresh first press
			sync_cnt_r <= 25'h0000000;
		end else if (!sync_over) begin
			sync_cnt_r <= sync_cnt_r + 25'h0000001;
		end
	end

	// ==========================================================
	// outputs
	// enable is taken from the next state so it drops on the same
	// edge as the state, not one later
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_enable_out <= 1'b0;
		end else begin
			out_enable_out <= (state_nxt == thc_pkg::THC_ON) && run_s && !start;
		end
	end

	// masks act on the flags only; a hidden error still locks the enable
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			disc_err1_out <= 1'b0;
		end else begin
			disc_err1_out <= use_disc1_in && err1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			disc_err2_out <= 1'b0;
		end else begin
			disc_err2_out <= use_disc2_in && err2;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_present_out <= 1'b0;
		end else begin
			fault_present_out <= use_fault_in && any_err;
		end
	end
endmodule : thc_monitor

// ### bench/thc_monitor_props.sv
// Purpose: port checks for the monitor
// Assumes: settings held while contacts move
// Notes: bound to every monitor
`timescale 1ns/10ps
module thc_monitor_props (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic p1_no_in,
	input wire logic p1_nc_in,
	input wire logic p2_no_in,
	input wire logic p2_nc_in,
	input wire logic [5:0] disc1_steps_in,
	input wire logic use_fault_in,
	input wire logic out_enable_out,
	input wire logic disc_err1_out,
	input wire logic fault_present_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_act;
		$rose(out_enable_out) |-> run_in && p1_no_in && !p1_nc_in && p2_no_in && !p2_nc_in;
	endproperty
	a_act: assert property (p_act) else $error("enable rose while inactive");
	property p_drop;
		out_enable_out && !p2_no_in |-> ##[1:8] !out_enable_out;
	endproperty
	a_drop: assert property (p_drop) else $error("enable held on release");
	property p_start;
		$rose(run_in) |-> !out_enable_out [*8];
	endproperty
	a_start: assert property (p_start) else $error("enable at start");
	property p_err_off;
		fault_present_out |-> ##1 !out_enable_out;
	endproperty
	a_err_off: assert property (p_err_off) else $error("enable with fault");
	property p_fault;
		disc_err1_out && use_fault_in |-> ##[0:1] fault_present_out;
	endproperty
	a_fault: assert property (p_fault) else $error("fault flag missing");
	property p_zero;
		disc1_steps_in == 6'h00 |-> !$rose(disc_err1_out);
	endproperty
	a_zero: assert property (p_zero) else $error("check ran at zero");
	property p_early;
		$rose(disc_err1_out) |-> $past(p1_no_in == p1_nc_in, 8);
	endproperty
	a_early: assert property (p_early) else $error("error too early");
	property p_idle;
		$rose(run_in) |-> ##[1:8] !disc_err1_out;
	endproperty
	a_idle: assert property (p_idle) else $error("error kept on start");
endmodule : thc_monitor_props
bind thc_monitor thc_monitor_props thc_monitor_props_inst (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.run_in(run_in),
	.p1_no_in(p1_no_in),
	.p1_nc_in(p1_nc_in),
	.p2_no_in(p2_no_in),
	.p2_nc_in(p2_nc_in),
	.disc1_steps_in(disc1_steps_in),
	.use_fault_in(use_fault_in),
	.out_enable_out(out_enable_out),
	.disc_err1_out(disc_err1_out),
	.fault_present_out(fault_present_out)
);

// ### bench/thc_switch_model.sv
// Purpose: two-hand switch, two contact pairs
// Assumes: press and stick levels from bench
// Notes: a stuck opener reads on with its closer
`timescale 1ns/10ps
module thc_switch_model (
	input wire logic press1_in,
	input wire logic press2_in,
	input wire logic stick1_in,
	input wire logic stick2_in,
	output logic p1_no_out,
	output logic p1_nc_out,
	output logic p2_no_out,
	output logic p2_nc_out
);
	assign p1_no_out = press1_in;
	assign p1_nc_out = !press1_in || stick1_in;
	assign p2_no_out = press2_in;
	assign p2_nc_out = !press2_in || stick2_in;
endmodule : thc_switch_model

// ### bench/thc_monitor_tb.sv
// Purpose: bench for the monitor
// Assumes: short step and window parameters
// Notes: one step is 10 cycles here
`timescale 1ns/10ps
module thc_monitor_tb;
	logic clk_in, rst_n_in, run_in, pr1, pr2, st1, st2, u1, u2, uf;
	logic p1_no, p1_nc, p2_no, p2_nc, en, e1, e2, flt;
	logic [5:0] d1, d2;
	int n_errors = 0;
	int checks_done = 0;
	thc_monitor #(.STEP_CYCLES(10), .SYNC_CYCLES(200)) thc_monitor_inst (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .run_in(run_in), .p1_no_in(p1_no), .p1_nc_in(p1_nc),
		.p2_no_in(p2_no), .p2_nc_in(p2_nc), .disc1_steps_in(d1), .disc2_steps_in(d2),
		.use_disc1_in(u1), .use_disc2_in(u2), .use_fault_in(uf), .out_enable_out(en),
		.disc_err1_out(e1), .disc_err2_out(e2), .fault_present_out(flt));
	thc_switch_model thc_switch_model_inst (.press1_in(pr1), .press2_in(pr2),
		.stick1_in(st1), .stick2_in(st2), .p1_no_out(p1_no), .p1_nc_out(p1_nc),
		.p2_no_out(p2_no), .p2_nc_out(p2_nc));
	initial begin
		clk_in = 1'h0;
		forever #20 clk_in = ~clk_in;
	end
	task chk(input logic s, input logic x);
		checks_done++;
		if (s !== x) begin
			n_errors++;
			$display("Error at %0t: got %b want %b", $time, s, x);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task wt(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : wt
	task press(input int a, input int b, input int n);
		pr1 = (a != 0);
		pr2 = (b != 0);
		wt(n);
	endtask : press
	// ==========
	// tests
	initial begin
		{rst_n_in, run_in, st1, st2} = 4'h0;
		{pr1, pr2, u1, u2, uf} = 5'h1f;
		d1 = 6'h03;
		d2 = 6'h03;
		wt(10);
		rst_n_in = 1'h1;
		run_in = 1'h1;
		wt(20);
		chk(en, 1'h0);
		press(0, 0, 20);
		press(1, 1, 20);
		chk(en, 1'h1);
		press(1, 0, 10);
		chk(en, 1'h0);
		$display("test enable done");
		press(0, 0, 20);
		press(1, 0, 250);
		press(1, 1, 20);
		chk(en, 1'h0);
		chk(flt, 1'h0);
		press(0, 0, 20);
		press(1, 0, 100);
		press(1, 1, 20);
		chk(en, 1'h1);
		$display("test window done");
		press(0, 0, 20);
		st1 = 1'h1;
		press(1, 0, 20);
		chk(e1, 1'h0);
		wt(30);
		chk(e1, 1'h1);
		chk(flt, 1'h1);
		st1 = 1'h0;
		press(0, 0, 20);
		press(1, 1, 20);
		chk(e1, 1'h0);
		chk(en, 1'h0);
		st1 = 1'h1;
		press(0, 0, 20);
		press(1, 0, 60);
		chk(e1, 1'h1);
		run_in = 1'h0;
		wt(10);
		run_in = 1'h1;
		wt(10);
		chk(e1, 1'h0);
		chk(flt, 1'h0);
		$display("test discrepancy done");
		press(0, 0, 20);
		d1 = 6'h00;
		press(1, 0, 80);
		chk(e1, 1'h0);
		st1 = 1'h0;
		st2 = 1'h1;
		uf = 1'h0;
		press(0, 1, 60);
		chk(e2, 1'h1);
		chk(flt, 1'h0);
		$display("test options done");
		print_verdict;
	end
	initial begin
		// the tests need under 900 clock cycles
		repeat (2000) @(posedge clk_in);
		n_errors++;
		print_verdict;
	end
endmodule : thc_monitor_tb
